// ==== verilog/sbl_params.svh ====
// Timing counts, codes and reset values of the serial boot image loader.
// Assumes a 250 MHz core clock; the half-period and start-up cycle counts below are derived from it.
`ifndef SBL_PARAMS_SVH
`define SBL_PARAMS_SVH

`define SBL_CLK_PERIOD_PS 4000
`define SBL_QSPI_SCLK_PERIOD_NS 20
`define SBL_SPI_SCLK_PERIOD_NS 400
// Half serial-clock periods; a clock period is a least time, so round up
`define SBL_QSPI_HALF_CYC ((`SBL_QSPI_SCLK_PERIOD_NS * 500 + `SBL_CLK_PERIOD_PS - 1) / `SBL_CLK_PERIOD_PS)
`define SBL_SPI_HALF_CYC ((`SBL_SPI_SCLK_PERIOD_NS * 500 + `SBL_CLK_PERIOD_PS - 1) / `SBL_CLK_PERIOD_PS)
// Latest boot start after reset release; a longest time, so round down
`define SBL_INIT_MAX_US 150
`define SBL_INIT_CYC ((`SBL_INIT_MAX_US * 1000000) / `SBL_CLK_PERIOD_PS)
`define SBL_READ_CMD 8'h03
`define SBL_START_ADDR 24'h000000
`define SBL_CRC_SKIP 32'h0D15AB1E
`define SBL_CRC_POLY 32'hEDB88320
`define SBL_CRC_INIT 32'hFFFFFFFF
`define SBL_CMD_BITS 32
`define SBL_RAM_AW 17

`endif

// ==== verilog/sbl_pkg.sv ====
// Types shared by the serial boot image loader.
// Assumes sbl_params.svh is on the include path.
`default_nettype none
`include "sbl_params.svh"
package sbl_pkg;
	typedef enum logic [6:0] {
		SBL_WAIT = 7'h01,
		SBL_CMD = 7'h02,
		SBL_SIZE = 7'h04,
		SBL_PROG = 7'h08,
		SBL_CRC = 7'h10,
		SBL_DONE = 7'h20,
		SBL_ERR = 7'h40
	} sbl_state_type;

	typedef struct packed {
		logic we;
		logic [`SBL_RAM_AW-1:0] addr;
		logic [7:0] data;
	} sbl_ram_wr_type;

	typedef struct packed {
		logic done;
		logic crc_error;
		logic quad;
	} sbl_status_type;
endpackage
`default_nettype wire

// ==== verilog/sbl_loader.sv ====
// Serial boot image loader: reads the boot image from serial flash address
// zero, writes the program to RAM from address zero, checks the CRC, starts.
// Assumes flash pins arrive asynchronously and RAM takes one write a cycle.
//
// Behaviour
// - Image: size word, then size times four bytes
// - CRC word; skip value bypasses the check
// - Size and CRC words assembled LS byte first
// - Program written from RAM zero, started there
// - CRC covers size word and program bytes
// - Reflected polynomial, all-ones start, inverted residue
// - Quad mode: six pins, 41.7 MHz serial clock
// - Read command then 24-bit address zero
// - Serial clock idles low, sample leading edge
// - Quad bytes arrive low nibble first
// - Quad boot pins are fixed
// - Single mode: four pins, 2.5 MHz clock
// - Single mode bytes arrive LS bit first
// - Boot starts within 150 us of reset
`default_nettype none
`include "sbl_params.svh"

module sbl_loader #(
	parameter int INIT_CYC = `SBL_INIT_CYC
) (
	// Clock, reset, enable
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_ce,
	// Boot mode strap, high for quad
	input wire logic i_quad_mode,
	// Flash pins
	output logic o_sel_n,
	output logic o_sclk,
	output logic o_mosi,
	input wire logic i_miso,
	input wire logic [3:0] i_quad_data_lines,
	output logic [3:0] o_quad_data_lines,
	output logic [3:0] o_quad_data_lines_oe,
	// RAM write port and program start
	output sbl_pkg::sbl_ram_wr_type o_ram,
	output logic o_start_exec,
	output logic [`SBL_RAM_AW-1:0] o_exec_addr,
	output sbl_pkg::sbl_status_type o_status
);
	localparam logic [7:0] QHALF = 8'(`SBL_QSPI_HALF_CYC);
	localparam logic [7:0] SHALF = 8'(`SBL_SPI_HALF_CYC);

	sbl_pkg::sbl_state_type state_reg;
	logic quad_reg;
	logic [31:0] wait_reg;
	logic [7:0] div_reg, hi_cnt_reg;
	logic [4:0] sync1_reg, sync2_reg;
	logic strap_meta_reg;
	logic [31:0] cmd_reg, size_reg, crcw_reg, crc_reg;
	logic [5:0] bit_reg;
	logic [3:0] samp_reg;
	logic [7:0] byte_reg;
	logic [1:0] word_byte_reg;
	logic [33:0] prog_reg;
	logic active, tick, rise, fall, byte_done;
	logic [7:0] half, byte_next;

	function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
		logic [31:0] r;
		r = c ^ {24'h000000, d};
		for (int i = 0; i < 8; i++) begin
			r = r[0] ? ((r >> 1) ^ `SBL_CRC_POLY) : (r >> 1);
		end
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers; only the second stage is read
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			sync1_reg <= 5'h00;
			sync2_reg <= 5'h00;
			strap_meta_reg <= 1'b0;
		end else if (i_ce) begin
			sync1_reg <= {i_miso, i_quad_data_lines};
			sync2_reg <= sync1_reg;
			// Strap's first stage; quad_reg is its second
			strap_meta_reg <= i_quad_mode;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Serial clock divider, mode 0: low while idle, sample on rising edge
	assign active = (state_reg == sbl_pkg::SBL_CMD) || (state_reg == sbl_pkg::SBL_SIZE) ||
		(state_reg == sbl_pkg::SBL_PROG) || (state_reg == sbl_pkg::SBL_CRC);
	assign half = quad_reg ? QHALF : SHALF;
	assign tick = active && (div_reg == half - 8'h01);
	assign rise = tick && !o_sclk;
	assign fall = tick && o_sclk;

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			div_reg <= 8'h00;
			o_sclk <= 1'b0;
			hi_cnt_reg <= 8'h00;
		end else if (i_ce) begin
			hi_cnt_reg <= o_sclk ? hi_cnt_reg + 8'h01 : 8'h00;
			if (!active || tick) begin
				div_reg <= 8'h00;
			end else begin
				div_reg <= div_reg + 8'h01;
			end
			if (!active) begin
				o_sclk <= 1'b0;
			end else if (tick) begin
				o_sclk <= !o_sclk;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Byte assembly: single LSB first, quad low nibble first
	always_comb begin
		if (quad_reg) begin
			byte_next = {sync2_reg[3:0], byte_reg[7:4]};
		end else begin
			byte_next = {sync2_reg[4], byte_reg[7:1]};
		end
	end
	assign byte_done = rise && (state_reg != sbl_pkg::SBL_CMD) &&
		(samp_reg == (quad_reg ? 4'h1 : 4'h7));

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			byte_reg <= 8'h00;
			samp_reg <= 4'h0;
		end else if (i_ce) begin
			if (rise && state_reg != sbl_pkg::SBL_CMD) begin
				byte_reg <= byte_next;
				samp_reg <= byte_done ? 4'h0 : samp_reg + 4'h1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Boot sequence
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			state_reg <= sbl_pkg::SBL_WAIT;
			quad_reg <= 1'b0;
			wait_reg <= 32'h00000000;
			cmd_reg <= 32'h00000000;
			bit_reg <= 6'h00;
			size_reg <= 32'h00000000;
			crcw_reg <= 32'h00000000;
			crc_reg <= `SBL_CRC_INIT;
			word_byte_reg <= 2'h0;
			prog_reg <= 34'h000000000;
		end else if (i_ce) begin
			case (state_reg)
				sbl_pkg::SBL_WAIT: begin
					quad_reg <= strap_meta_reg;
					wait_reg <= wait_reg + 32'h00000001;
					if (wait_reg >= 32'(INIT_CYC)) begin
						state_reg <= sbl_pkg::SBL_CMD;
						cmd_reg <= {`SBL_READ_CMD, `SBL_START_ADDR};
						bit_reg <= 6'h00;
						crc_reg <= `SBL_CRC_INIT;
					end
				end
				sbl_pkg::SBL_CMD: begin
					if (fall) begin
						cmd_reg <= {cmd_reg[30:0], 1'b0};
					end
					if (rise) begin
						bit_reg <= bit_reg + 6'h01;
						if (bit_reg == 6'(`SBL_CMD_BITS - 1)) begin
							state_reg <= sbl_pkg::SBL_SIZE;
						end
					end
				end
				sbl_pkg::SBL_SIZE: begin
					if (byte_done) begin
						size_reg <= {byte_next, size_reg[31:8]};
						crc_reg <= crc_byte(crc_reg, byte_next);
						word_byte_reg <= word_byte_reg + 2'h1;
						if (word_byte_reg == 2'h3) begin
							state_reg <= ({byte_next, size_reg[31:8]} == 32'h00000000) ?
								sbl_pkg::SBL_CRC : sbl_pkg::SBL_PROG;
						end
					end
				end
				sbl_pkg::SBL_PROG: begin
					if (byte_done) begin
						crc_reg <= crc_byte(crc_reg, byte_next);
						prog_reg <= prog_reg + 34'h000000001;
						if (prog_reg + 34'h000000001 == {size_reg, 2'b00}) begin
							state_reg <= sbl_pkg::SBL_CRC;
						end
					end
				end
				sbl_pkg::SBL_CRC: begin
					if (byte_done) begin
						crcw_reg <= {byte_next, crcw_reg[31:8]};
						word_byte_reg <= word_byte_reg + 2'h1;
						if (word_byte_reg == 2'h3) begin
							if ({byte_next, crcw_reg[31:8]} == `SBL_CRC_SKIP ||
								{byte_next, crcw_reg[31:8]} == ~crc_reg) begin
								state_reg <= sbl_pkg::SBL_DONE;
							end else begin
								state_reg <= sbl_pkg::SBL_ERR;
							end
						end
					end
				end
				sbl_pkg::SBL_DONE: state_reg <= sbl_pkg::SBL_DONE;
				sbl_pkg::SBL_ERR: state_reg <= sbl_pkg::SBL_ERR;
				default: state_reg <= sbl_pkg::SBL_WAIT;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// RAM write port, registered
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_ram <= '0;
		end else if (i_ce) begin
			o_ram.we <= byte_done && state_reg == sbl_pkg::SBL_PROG;
			o_ram.addr <= prog_reg[`SBL_RAM_AW-1:0];
			o_ram.data <= byte_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Pins: fixed assignment, select held low over the whole stream
	// Select stays low until the clock is back low, so the clock never stands
	// high while the flash is deselected
	assign o_sel_n = !(active || o_sclk);
	assign o_mosi = (state_reg == sbl_pkg::SBL_CMD) && !quad_reg && cmd_reg[31];
	assign o_quad_data_lines = {3'b000, cmd_reg[31] && state_reg == sbl_pkg::SBL_CMD};
	// Quad mode drives the command on line 0 only; the lines are inputs for data
	assign o_quad_data_lines_oe = {3'b000, quad_reg && state_reg == sbl_pkg::SBL_CMD};
	assign o_start_exec = state_reg == sbl_pkg::SBL_DONE;
	assign o_exec_addr = '0;
	assign o_status = '{done: state_reg == sbl_pkg::SBL_DONE,
		crc_error: state_reg == sbl_pkg::SBL_ERR, quad: quad_reg};

	////////////////////////////////////////////////////////////////////////////
	// Checks
	sclk_idle_low_a: assert property (@(posedge i_clk) disable iff (i_rst)
		o_sel_n |-> !o_sclk) else $error("serial clock not low while idle");
	read_cmd_word_a: assert property (@(posedge i_clk) disable iff (i_rst)
		$rose(state_reg == sbl_pkg::SBL_CMD) |-> cmd_reg == 32'h03000000)
		else $error("read command or address wrong");
	quad_half_a: assert property (@(posedge i_clk) disable iff (i_rst)
		$fell(o_sclk) && quad_reg && !o_sel_n |-> $past(hi_cnt_reg) == 8'h02)
		else $error("quad serial clock high time wrong");
	single_half_a: assert property (@(posedge i_clk) disable iff (i_rst)
		$fell(o_sclk) && !quad_reg && !o_sel_n |-> $past(hi_cnt_reg) == 8'h31)
		else $error("single serial clock high time wrong");
	boot_start_a: assert property (@(posedge i_clk) disable iff (i_rst)
		wait_reg > 32'(INIT_CYC) |-> state_reg != sbl_pkg::SBL_WAIT)
		else $error("boot started late");
	crc_seed_a: assert property (@(posedge i_clk) disable iff (i_rst)
		$rose(state_reg == sbl_pkg::SBL_SIZE) |-> crc_reg == 32'hFFFFFFFF)
		else $error("crc seed wrong");
	first_addr_a: assert property (@(posedge i_clk) disable iff (i_rst)
		$rose(state_reg == sbl_pkg::SBL_PROG) |-> prog_reg == 34'h000000000 && !o_ram.we)
		else $error("first program byte not at address zero");
	skip_crc_a: assert property (@(posedge i_clk) disable iff (i_rst || !i_ce)
		byte_done && state_reg == sbl_pkg::SBL_CRC && word_byte_reg == 2'h3 &&
		{byte_next, crcw_reg[31:8]} == 32'h0D15AB1E |=> o_start_exec)
		else $error("skip value did not start program");
	error_hold_a: assert property (@(posedge i_clk) disable iff (i_rst)
		o_status.crc_error |=> o_status.crc_error && !o_start_exec)
		else $error("error state left or program started");
endmodule
`default_nettype wire

// ==== tb/sbl_flash_model.sv ====
// Serial flash model: answers one read from address zero with mem bytes.
// Assumes 32 command bits on one line, then streams while selected.
`default_nettype none
module sbl_flash_model (
	// Flash pins
	input wire logic i_sel_n,
	input wire logic i_sclk,
	input wire logic i_cmd_bit,
	input wire logic i_quad,
	output logic o_miso,
	output logic [3:0] o_quad_data_lines,
	// Captured command
	output logic [31:0] o_cmd
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] mem [0:63];
	int cnt = 0;
	initial begin
		o_miso = 1'b0;
		o_quad_data_lines = 4'h0;
	end
	always @(posedge i_sclk or posedge i_sel_n) begin
		if (i_sel_n) begin
			cnt <= 0;
		end else begin
			if (cnt < 32) o_cmd <= {o_cmd[30:0], i_cmd_bit};
			cnt <= cnt + 1;
		end
	end
	// Change on the fall so data has half a period to settle before the rise
	always @(negedge i_sclk or posedge i_sel_n) begin
		int pos;
		pos = cnt - 32;
		if (i_sel_n || pos < 0) begin
			// Undriven lines must not look like held data
			o_miso <= ~o_miso;
			o_quad_data_lines <= ~o_quad_data_lines;
		end else if (i_quad) begin
			o_quad_data_lines <= pos[0] ? mem[pos/2][7:4] : mem[pos/2][3:0];
		end else begin
			o_miso <= mem[pos/8][pos%8];
		end
	end
endmodule
`default_nettype wire

// ==== tb/sbl_loader_tb_top.sv ====
// Bench for the boot image loader: builds images, boots, checks RAM and status.
// Assumes the flash model in sbl_flash_model.sv.
`default_nettype none
`include "sbl_params.svh"
module sbl_loader_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int INIT = 10;
	logic i_clk = 1'b0;
	logic i_rst = 1'b1;
	logic i_quad_mode = 1'b0;
	logic o_sel_n, o_sclk, o_mosi, miso, sclk_d, o_start_exec;
	logic addr_ok = 1'b1;
	logic [3:0] q_out, q_oe, q_flash, q_in;
	logic [3:0] oe_seen = 4'h0;
	logic [31:0] cmd;
	logic [7:0] ram [0:63];
	logic [`SBL_RAM_AW-1:0] o_exec_addr;
	sbl_pkg::sbl_ram_wr_type o_ram;
	sbl_pkg::sbl_status_type o_status;
	int mismatches = 0;
	int n_tests = 0;
	int cyc = 0;
	int t_sel, t_r1, t_r2, n_wr;
	always #2 i_clk = ~i_clk;
	assign q_in = (q_oe & q_out) | (~q_oe & q_flash);
	sbl_loader #(.INIT_CYC(INIT)) dut_u (
		.i_clk(i_clk), .i_rst(i_rst), .i_ce(1'b1), .i_quad_mode(i_quad_mode),
		.o_sel_n(o_sel_n), .o_sclk(o_sclk), .o_mosi(o_mosi), .i_miso(miso),
		.i_quad_data_lines(q_in), .o_quad_data_lines(q_out),
		.o_quad_data_lines_oe(q_oe), .o_ram(o_ram), .o_start_exec(o_start_exec),
		.o_exec_addr(o_exec_addr), .o_status(o_status));
	sbl_flash_model flash_u (
		.i_sel_n(o_sel_n), .i_sclk(o_sclk), .i_cmd_bit(i_quad_mode ? q_out[0] : o_mosi),
		.i_quad(i_quad_mode), .o_miso(miso), .o_quad_data_lines(q_flash), .o_cmd(cmd));
	////////////////////////////////////////////////////////////////////////////
	always @(posedge i_clk) begin
		if (i_rst) begin
			// Every reset restarts the records, so cycles count from release
			cyc <= 0;
			t_sel <= 0;
			t_r1 <= 0;
			t_r2 <= 0;
			n_wr <= 0;
			sclk_d <= 1'b0;
			oe_seen <= 4'h0;
			addr_ok <= 1'b1;
		end else begin
			cyc <= cyc + 1;
			sclk_d <= o_sclk;
			oe_seen <= oe_seen | q_oe;
			if (!o_sel_n && t_sel == 0) t_sel <= cyc;
			if (o_sclk && !sclk_d && t_r1 == 0) t_r1 <= cyc;
			else if (o_sclk && !sclk_d && t_r2 == 0) t_r2 <= cyc;
			if (o_ram.we === 1'b1) begin
				ram[n_wr[5:0]] <= o_ram.data;
				addr_ok <= addr_ok & (o_ram.addr === n_wr[`SBL_RAM_AW-1:0]);
				n_wr <= n_wr + 1;
			end
		end
	end
	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask
	////////////////////////////////////////////////////////////////////////////
	// Mode 0 good CRC, 1 skip value, 2 corrupted CRC
	task automatic run(input logic quad, input int size, input int mode);
		logic [31:0] crc;
		int n;
		n = 8 + size * 4;
		crc = 32'hFFFFFFFF;
		for (int i = 0; i < 4; i++) flash_u.mem[i] = 8'(size >> (8 * i));
		for (int i = 4; i < n - 4; i++) flash_u.mem[i] = 8'(i * 59 + 17);
		for (int i = 0; i < n - 4; i++) begin
			crc ^= {24'h000000, flash_u.mem[i]};
			for (int b = 0; b < 8; b++) crc = (crc >> 1) ^ (crc[0] ? `SBL_CRC_POLY : 32'h0);
		end
		crc = (mode == 1) ? `SBL_CRC_SKIP : ~crc ^ ((mode == 2) ? 32'h100 : 32'h0);
		for (int i = 0; i < 4; i++) flash_u.mem[n - 4 + i] = 8'(crc >> (8 * i));
		i_rst <= 1'b1;
		i_quad_mode <= quad;
		repeat (5) @(posedge i_clk);
		i_rst <= 1'b0;
		for (int k = 0; k < 40000 && o_status.done !== 1'b1 && o_status.crc_error !== 1'b1; k++)
			@(posedge i_clk);
		if (o_status.done !== 1'b1 && o_status.crc_error !== 1'b1) begin
			mismatches++;
			stop_test();
		end
		repeat (2) @(posedge i_clk);
		chk(cmd, {`SBL_READ_CMD, `SBL_START_ADDR});
		// Counted from the first edge after release
		chk(t_sel > 0 && t_sel <= INIT + 1, 1'b1);
		chk(t_r2 - t_r1, 2 * (quad ? `SBL_QSPI_HALF_CYC : `SBL_SPI_HALF_CYC));
		chk(oe_seen, quad ? 4'h1 : 4'h0);
		chk({o_sel_n, o_sclk}, 2'b10);
		chk(o_status, {mode != 2, mode == 2, quad});
		chk(o_start_exec, mode != 2);
		chk(o_exec_addr, 0);
		chk(n_wr, size * 4);
		chk(addr_ok, 1'b1);
		for (int i = 0; i < size * 4; i++) chk(ram[i], flash_u.mem[i + 4]);
	endtask
	task automatic single_good(); run(1'b0, 2, 0); endtask
	task automatic quad_skip(); run(1'b1, 3, 1); endtask
	task automatic single_bad(); run(1'b0, 1, 2); endtask
	task automatic quad_empty(); run(1'b1, 0, 0); endtask
	initial begin
		single_good();
		quad_skip();
		single_bad();
		quad_empty();
		stop_test();
	end
endmodule
`default_nettype wire
